// [src/fcis_ctrl.v]
// Flash controller interrupts, low-power handshakes, security and reset initialisation
`timescale 1ns/1ns
`include "fcis_defs.vh"

// Overview of operation
// RL1 - Command interrupt high while done flag and done enable both set.
// RL2 - Error interrupt high while single-bit fault flag and its enable set.
// RL3 - Wait mode does not disturb operation; done interrupt wakes the system.
// RL4 - Stop request during a running command is granted only after completion.
// RL5 - Lock-state register loads from stored security byte during reset.
// RL6 - Newly programmed security byte takes effect only after next reset.
// RL7 - Backdoor verify honoured only with unlock enabled; compares four 16-bit keys.
// RL8 - Full key match forces protection state field to unsecure code 10.
// RL9 - Stored or presented keys of all zeros or all ones never match.
// RL10 - Flash reads return invalid data while backdoor verify runs.
// RL11 - Failed key comparison blocks further backdoor verify until reset.
// RL12 - Backdoor verify leaves security byte, keys and flash protection untouched.
// RL13 - Reset initialisation loads configuration, protections, option and lock state.
// RL14 - Errors during initialisation fall back to protected, secured defaults.
// RL15 - Double-bit fault during initialisation sets both verify error bits.
// RL16 - Done flag low during initialisation, set when it finishes.
// RL17 - CPU accesses stall during part of initialisation; reads allowed afterward.
// RL18 - Reset during a command aborts it at once; target contents undefined.
// RL19 - Both interrupt requests are levels following flag and enable.
module fcis_ctrl #(
	parameter INIT_CYC = `FCIS_INIT_CYC,
	parameter HOLD_CYC = `FCIS_HOLD_CYC
) (
	input wire i_mclk,                 // System clock
	input wire i_rst_b,                // Async reset, active low
	input wire i_hsel,                 // AHB select
	input wire [11:0] i_haddr,         // AHB address
	input wire [1:0] i_htrans,         // AHB transfer type
	input wire i_hwrite,               // AHB write
	input wire [2:0] i_hsize,          // AHB size
	input wire [31:0] i_hwdata,        // AHB write data
	input wire i_hready,               // AHB ready in
	output reg [31:0] o_hrdata,        // AHB read data
	output reg o_hreadyout,            // AHB ready out
	output reg o_hresp,                // AHB response, always OKAY
	input wire [7:0] i_nvm_sec_byte,   // Stored security byte
	input wire [63:0] i_nvm_keys,      // Stored backdoor keys, key0 in low bits
	input wire [7:0] i_nvm_pprot,      // Stored program flash protection
	input wire [7:0] i_nvm_eprot,      // Stored eeprom protection
	input wire [7:0] i_nvm_option,     // Stored option byte
	input wire [7:0] i_nvm_blkcfg,     // Stored block configuration
	input wire i_nvm_load_err,         // Load error during init
	input wire i_nvm_dbl_fault,        // Double-bit fault during init
	input wire i_sbf_event,            // Single-bit correction on a read pulse
	input wire i_stop_req,             // Stop mode request
	output reg o_stop_ack,             // Stop entry granted
	output reg o_cmd_irq,              // Command done interrupt
	output reg o_err_irq,              // Single-bit fault interrupt
	output reg o_irq,                  // Summary interrupt
	output reg o_read_invalid,         // Flash reads give invalid data
	output reg o_cpu_hold,             // CPU access stall
	output reg [1:0] o_prot_state,     // Live protection state
	output reg [7:0] o_blk_cfg         // Loaded block configuration
);

	localparam ST_INIT = 2'h0;
	localparam ST_IDLE = 2'h1;
	localparam ST_VERIFY = 2'h2;
	localparam ST_CMD = 2'h3;

	reg [1:0] state_q;
	reg [15:0] cnt_q;
	reg done_q;
	reg [1:0] verr_q;
	reg done_ie_q;
	reg sbf_q;
	reg sbf_ie_q;
	reg [7:0] lock_q;
	reg [7:0] pprot_q;
	reg [7:0] eprot_q;
	reg [7:0] option_q;
	reg [31:0] key01_q;
	reg [31:0] key23_q;
	reg bd_block_q;
	reg [1:0] ist_q;
	reg [1:0] ien_q;
	reg stop_pend_q;
	reg ph_wr_q;
	reg ph_rd_q;
	reg [11:0] ph_addr_q;
	reg done_rise_q;

	function key_ok;
		input [15:0] k;
		begin
			key_ok = (k != `FCIS_KEY_ZERO) && (k != `FCIS_KEY_ONES); // [RL9]
		end
	endfunction

	wire ap = i_hsel && i_hready && i_htrans[1];
	wire wr = ph_wr_q;
	wire [7:0] wb = i_hwdata[7:0];
	wire keys_match = key_ok(key01_q[15:0]) && key_ok(key01_q[31:16]) &&
		key_ok(key23_q[15:0]) && key_ok(key23_q[31:16]) &&
		(key01_q == i_nvm_keys[31:0]) && (key23_q == i_nvm_keys[63:32]); // [RL7] [RL9]
	wire cmd_wr = wr && ph_addr_q == `FCIS_OFF_CMD && state_q == ST_IDLE && done_q;
	wire bd_go = cmd_wr && wb == `FCIS_CMD_BACKDOOR && !bd_block_q &&
		lock_q[`FCIS_LK_BACKDOOR_UNLOCK_ENABLE_HI:`FCIS_LK_BACKDOOR_UNLOCK_ENABLE_LO] == `FCIS_BACKDOOR_UNLOCK_ENABLE_ON; // [RL7] [RL11]
	wire gen_go = cmd_wr && wb == `FCIS_CMD_GENERIC;
	wire cnt_end = cnt_q == 16'h0000;

	// Bus slave: zero-wait outside the init hold, registered address phase
	always @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			ph_wr_q <= 1'b0;
			ph_rd_q <= 1'b0;
			ph_addr_q <= 12'h000;
		end else begin
			ph_wr_q <= ap && i_hwrite;
			ph_rd_q <= ap && !i_hwrite;
			if (ap) begin
				ph_addr_q <= i_haddr;
			end
		end
	end

	// Sequencer: reset init, backdoor verify, generic command
	always @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			// Reset aborts any command at once; target contents left undefined [RL18]
			state_q <= ST_INIT;
			cnt_q <= 16'h0000;
			done_q <= 1'b0;
			verr_q <= 2'h0;
			lock_q <= `FCIS_DEF_LOCK;
			pprot_q <= `FCIS_DEF_PROT;
			eprot_q <= `FCIS_DEF_PROT;
			option_q <= `FCIS_DEF_OPTION;
			o_blk_cfg <= 8'h00;
			bd_block_q <= 1'b0;
			o_read_invalid <= 1'b0;
			o_cpu_hold <= 1'b1;
			o_prot_state <= 2'h0;
			done_rise_q <= 1'b0;
		end else begin
			done_rise_q <= 1'b0;
			o_prot_state <= lock_q[`FCIS_LK_PROT_HI:`FCIS_LK_PROT_LO];
			case (state_q)
			ST_INIT: begin
				done_q <= 1'b0; // [RL16]
				if (cnt_q == 16'h0000 && o_cpu_hold && !done_rise_q && verr_q == 2'h0 && o_blk_cfg == 8'h00 &&
					lock_q == `FCIS_DEF_LOCK && pprot_q == `FCIS_DEF_PROT) begin
					cnt_q <= INIT_CYC[15:0];
				end else if (!cnt_end) begin
					cnt_q <= cnt_q - 16'h0001;
				end
				if (cnt_q == INIT_CYC[15:0] - HOLD_CYC[15:0]) begin
					o_cpu_hold <= 1'b0; // [RL17]
				end
				if (cnt_q == 16'h0001) begin
					if (i_nvm_load_err || i_nvm_dbl_fault) begin
						lock_q <= `FCIS_DEF_LOCK; // [RL14]
						pprot_q <= `FCIS_DEF_PROT;
						eprot_q <= `FCIS_DEF_PROT;
						option_q <= `FCIS_DEF_OPTION;
						o_blk_cfg <= 8'h00;
					end else begin
						lock_q <= i_nvm_sec_byte; // [RL5] [RL13]
						pprot_q <= i_nvm_pprot;
						eprot_q <= i_nvm_eprot;
						option_q <= i_nvm_option;
						o_blk_cfg <= i_nvm_blkcfg;
					end
					if (i_nvm_dbl_fault) begin
						verr_q <= 2'h3; // [RL15]
					end
					state_q <= ST_IDLE;
					done_q <= 1'b1; // [RL16]
					done_rise_q <= 1'b1;
				end
			end
			ST_IDLE: begin
				if (bd_go) begin
					state_q <= ST_VERIFY;
					cnt_q <= `FCIS_VERIFY_CYC;
					done_q <= 1'b0;
					o_read_invalid <= 1'b1; // [RL10]
				end else if (gen_go) begin
					state_q <= ST_CMD;
					cnt_q <= `FCIS_CMD_CYC;
					done_q <= 1'b0;
					verr_q <= 2'h0;
				end
			end
			ST_VERIFY: begin
				cnt_q <= cnt_q - 16'h0001;
				if (cnt_q == 16'h0001) begin
					// Only the live lock field moves; stored byte, keys, protections stay [RL12]
					if (keys_match) begin
						lock_q[`FCIS_LK_PROT_HI:`FCIS_LK_PROT_LO] <= `FCIS_PROT_UNSEC; // [RL8]
					end else begin
						bd_block_q <= 1'b1; // [RL11]
					end
					o_read_invalid <= 1'b0;
					state_q <= ST_IDLE;
					done_q <= 1'b1;
					done_rise_q <= 1'b1;
				end
			end
			ST_CMD: begin
				cnt_q <= cnt_q - 16'h0001;
				if (cnt_q == 16'h0001) begin
					state_q <= ST_IDLE;
					done_q <= 1'b1;
					done_rise_q <= 1'b1;
				end
			end
			default: begin
				state_q <= ST_IDLE;
			end
			endcase
			// Lock state is never written from the bus, so a new stored byte waits for reset [RL6]
			if (state_q != ST_INIT && wr && ph_addr_q == `FCIS_OFF_PPROT) begin
				pprot_q <= wb;
			end
			if (state_q != ST_INIT && wr && ph_addr_q == `FCIS_OFF_EPROT) begin
				eprot_q <= wb;
			end
		end
	end

	// Software registers, sticky events, stop handshake
	always @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			done_ie_q <= 1'b0;
			sbf_q <= 1'b0;
			sbf_ie_q <= 1'b0;
			key01_q <= 32'h00000000;
			key23_q <= 32'h00000000;
			ist_q <= 2'h0;
			ien_q <= 2'h0;
			stop_pend_q <= 1'b0;
			o_stop_ack <= 1'b0;
			o_cmd_irq <= 1'b0;
			o_err_irq <= 1'b0;
			o_irq <= 1'b0;
		end else begin
			if (wr && ph_addr_q == `FCIS_OFF_CONFIG) begin
				done_ie_q <= wb[`FCIS_CF_DONE_IE];
			end
			if (wr && ph_addr_q == `FCIS_OFF_ERRCFG) begin
				sbf_ie_q <= wb[`FCIS_ER_SBF];
			end
			// Set wins over a same-cycle write-one clear
			if (i_sbf_event) begin
				sbf_q <= 1'b1;
			end else if (wr && ph_addr_q == `FCIS_OFF_ERRSTAT && wb[`FCIS_ER_SBF]) begin
				sbf_q <= 1'b0;
			end
			if (wr && ph_addr_q == `FCIS_OFF_KEY01) begin
				key01_q <= i_hwdata;
			end
			if (wr && ph_addr_q == `FCIS_OFF_KEY23) begin
				key23_q <= i_hwdata;
			end
			if (wr && ph_addr_q == `FCIS_OFF_IRQ_EN) begin
				ien_q <= i_hwdata[1:0];
			end
			if (wr && ph_addr_q == `FCIS_OFF_IRQ_CLR) begin
				ist_q <= (ist_q & ~i_hwdata[1:0]) | {i_sbf_event, done_rise_q};
			end else begin
				ist_q <= ist_q | {i_sbf_event, done_rise_q};
			end
			// Stop held off until the running command ends [RL4]
			stop_pend_q <= i_stop_req;
			o_stop_ack <= stop_pend_q && i_stop_req && done_q && state_q == ST_IDLE;
			// Wait mode has no input here: the done interrupt keeps running to wake the core [RL3]
			o_cmd_irq <= done_q && done_ie_q; // [RL1] [RL19]
			o_err_irq <= sbf_q && sbf_ie_q; // [RL2] [RL19]
			o_irq <= |(ist_q & ien_q);
		end
	end

	// Read mux and ready; no wait states except during the init hold [RL17]
	always @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_hrdata <= 32'h00000000;
			o_hreadyout <= 1'b1;
			o_hresp <= 1'b0;
		end else begin
			o_hresp <= 1'b0;
			o_hreadyout <= !(o_cpu_hold && ap) && !(o_cpu_hold && !o_hreadyout);
			if (ap && !i_hwrite) begin
				case (i_haddr)
				`FCIS_OFF_STATUS: o_hrdata <= {24'h000000, done_q, 5'h00, verr_q};
				`FCIS_OFF_CONFIG: o_hrdata <= {24'h000000, done_ie_q, 7'h00};
				`FCIS_OFF_ERRSTAT: o_hrdata <= {31'h00000000, sbf_q};
				`FCIS_OFF_ERRCFG: o_hrdata <= {31'h00000000, sbf_ie_q};
				`FCIS_OFF_LOCK: o_hrdata <= {24'h000000, lock_q};
				`FCIS_OFF_PPROT: o_hrdata <= {24'h000000, pprot_q};
				`FCIS_OFF_EPROT: o_hrdata <= {24'h000000, eprot_q};
				`FCIS_OFF_OPTION: o_hrdata <= {24'h000000, option_q};
				`FCIS_OFF_CTRL: o_hrdata <= {28'h0000000, bd_block_q, o_read_invalid, state_q};
				`FCIS_OFF_IRQ_STAT: o_hrdata <= {30'h00000000, ist_q};
				`FCIS_OFF_IRQ_EN: o_hrdata <= {30'h00000000, ien_q};
				default: o_hrdata <= 32'h00000000;
				endcase
			end
		end
	end

endmodule

// [src/fcis_defs.vh]
// Register offsets, field positions, reset values and timing counts for the flash control block
`ifndef FCIS_DEFS_VH
`define FCIS_DEFS_VH

// Register byte offsets on the AHB-Lite bus
`define FCIS_OFF_STATUS 12'h000
`define FCIS_OFF_CONFIG 12'h004
`define FCIS_OFF_ERRSTAT 12'h008
`define FCIS_OFF_ERRCFG 12'h00C
`define FCIS_OFF_LOCK 12'h010
`define FCIS_OFF_PPROT 12'h014
`define FCIS_OFF_EPROT 12'h018
`define FCIS_OFF_OPTION 12'h01C
`define FCIS_OFF_CMD 12'h020
`define FCIS_OFF_KEY01 12'h024
`define FCIS_OFF_KEY23 12'h028
`define FCIS_OFF_CTRL 12'h02C
`define FCIS_OFF_IRQ_STAT 12'h030
`define FCIS_OFF_IRQ_EN 12'h034
`define FCIS_OFF_IRQ_CLR 12'h038

// Status register fields
`define FCIS_ST_DONE 7
`define FCIS_ST_VERR1 1
`define FCIS_ST_VERR0 0
// Config register fields
`define FCIS_CF_DONE_IE 7
// Error status/config fields
`define FCIS_ER_SBF 0
// Lock state fields
`define FCIS_LK_BACKDOOR_UNLOCK_ENABLE_HI 7
`define FCIS_LK_BACKDOOR_UNLOCK_ENABLE_LO 6
`define FCIS_LK_PROT_HI 1
`define FCIS_LK_PROT_LO 0
`define FCIS_BACKDOOR_UNLOCK_ENABLE_ON 2'h2
`define FCIS_PROT_UNSEC 2'h2

// Command codes written to the command register
`define FCIS_CMD_BACKDOOR 8'h0C
`define FCIS_CMD_GENERIC 8'h01

// Defaults used when the reset load fails: fully protected, secured
`define FCIS_DEF_LOCK 8'h00
`define FCIS_DEF_PROT 8'h00
`define FCIS_DEF_OPTION 8'h00

// Key value limits
`define FCIS_KEY_ZERO 16'h0000
`define FCIS_KEY_ONES 16'hFFFF

// Timing
`define FCIS_CLK_MHZ 100
`define FCIS_INIT_NS 200
`define FCIS_INIT_CYC ((`FCIS_INIT_NS * `FCIS_CLK_MHZ + 999) / 1000)
`define FCIS_HOLD_NS 100
`define FCIS_HOLD_CYC ((`FCIS_HOLD_NS * `FCIS_CLK_MHZ + 999) / 1000)
`define FCIS_VERIFY_CYC 16'h0008
`define FCIS_CMD_CYC 16'h0010

`endif

// [tb/fcis_checker_assertions.sv]
// Port-level checks for the flash control block
`timescale 1ns/1ns
module fcis_checker #(
	parameter INIT_CYC = 20,
	parameter HOLD_CYC = 10
) (
	input wire i_mclk, // Clock
	input wire i_rst_b, // Reset
	input wire i_stop_req, // Stop request
	input wire o_hreadyout, // Ready
	input wire o_stop_ack, // Stop grant
	input wire o_cmd_irq, // Done irq
	input wire o_err_irq, // Fault irq
	input wire o_irq, // Summary irq
	input wire o_read_invalid, // Reads invalid
	input wire o_cpu_hold // Init stall
);
	localparam int HMAX = HOLD_CYC + 3;
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_rst_b);
	AST_RST_QUIET:
	assert property (disable iff (1'b0) !i_rst_b |-> !o_cmd_irq && !o_err_irq && !o_irq && !o_read_invalid)
		else $error("output active in reset");
	AST_HOLD_START:
	assert property ($rose(i_rst_b) |-> o_cpu_hold) else $error("no stall after reset");
	AST_HOLD_END:
	assert property ($rose(i_rst_b) |-> ##[1:HMAX] !o_cpu_hold) else $error("stall never released");
	AST_STALL_ONLY_HOLD:
	assert property (!o_hreadyout |-> o_cpu_hold || $past(o_cpu_hold)) else $error("wait state outside stall");
	AST_HOLD_RELEASE:
	assert property ($fell(o_cpu_hold) |=> o_hreadyout) else $error("access still stalled");
	AST_DONE_IN_INIT:
	assert property (o_cpu_hold |-> !o_cmd_irq) else $error("done irq during init");
	AST_VERIFY_IN_INIT:
	assert property (o_cpu_hold |-> !o_read_invalid) else $error("command during init");
	AST_VERIFY_SPAN:
	assert property ($rose(o_read_invalid) |-> o_read_invalid[*8] ##1 !o_read_invalid)
		else $error("invalid read span wrong");
	AST_STOP_IDLE:
	assert property (o_read_invalid |-> !o_stop_ack) else $error("stop granted mid command");
	AST_STOP_CAUSE:
	assert property (o_stop_ack |-> $past(i_stop_req)) else $error("stop grant without request");
endmodule
bind fcis_ctrl fcis_checker #(.INIT_CYC(INIT_CYC), .HOLD_CYC(HOLD_CYC)) chk_u (.i_mclk(i_mclk),
	.i_rst_b(i_rst_b), .i_stop_req(i_stop_req), .o_hreadyout(o_hreadyout), .o_stop_ack(o_stop_ack),
	.o_cmd_irq(o_cmd_irq), .o_err_irq(o_err_irq), .o_irq(o_irq), .o_read_invalid(o_read_invalid),
	.o_cpu_hold(o_cpu_hold));

// [tb/fcis_nvm_model.sv]
// Stored configuration field read by the flash block at reset
`timescale 1ns/1ns
module fcis_nvm_model #(
	parameter [63:0] KEYS = 64'h4D3C_2B1A_7F6E_5D4C,
	parameter [7:0] SEC = 8'h80
) (
	input wire i_mclk, // Clock
	input wire i_prog, // Program security byte
	input wire [7:0] i_prog_byte, // New byte
	input wire [1:0] i_mode, // 1 load error, 2 double fault, 3 zero keys
	output reg [7:0] o_sec_byte, // Security byte
	output wire [63:0] o_keys, // Keys
	output wire [7:0] o_pprot, // Flash protection
	output wire [7:0] o_eprot, // Eeprom protection
	output wire [7:0] o_option, // Option
	output wire [7:0] o_blkcfg, // Block config
	output wire o_load_err, // Load failed
	output wire o_dbl_fault // Double fault
);
	initial o_sec_byte = SEC;
	// Array changes now, block only sees it at its next reset
	always @(posedge i_mclk) begin
		if (i_prog) begin
			o_sec_byte <= i_prog_byte;
		end
	end
	// Zero keys only when a scenario asks for the illegal value
	assign o_keys = (i_mode == 2'h3) ? 64'h0 : KEYS;
	assign o_pprot = 8'hA5;
	assign o_eprot = 8'h3C;
	assign o_option = 8'h5A;
	assign o_blkcfg = 8'hC3;
	assign o_load_err = (i_mode == 2'h1);
	assign o_dbl_fault = (i_mode == 2'h2);
endmodule

// [tb/flash_ctrl_irq_security_init_bench.sv]
// Self-checking bench for the flash control block
`timescale 1ns/1ns
`include "fcis_defs.vh"
module flash_ctrl_irq_security_init_bench;
	reg i_mclk = 1'b0;
	reg i_rst_b = 1'b1;
	reg hsel = 1'b0, hwrite = 1'b0, sbf = 1'b0, stop = 1'b0, prog = 1'b0, rd_pend = 1'b0;
	reg [11:0] haddr = 12'h000;
	reg [1:0] htrans = 2'h0, mode = 2'h0;
	reg [2:0] hsize = 3'h0;
	reg [31:0] hwdata = 32'h0, seed = 32'hC9A5;
	reg [7:0] pbyte = 8'h00;
	reg [63:0] q[$];
	integer errors = 0, n_checks = 0, n;
	wire [31:0] hrdata;
	wire rdy, resp, ack, cirq, eirq, irq, rinv, hold, lerr, dflt;
	wire [1:0] prot;
	wire [7:0] sec, pp, ep, op, bc, blk;
	wire [63:0] keys;
	initial forever #5 i_mclk = ~i_mclk;
	fcis_nvm_model nvm_u (.i_mclk(i_mclk), .i_prog(prog), .i_prog_byte(pbyte), .i_mode(mode), .o_sec_byte(sec),
		.o_keys(keys), .o_pprot(pp), .o_eprot(ep), .o_option(op), .o_blkcfg(bc), .o_load_err(lerr), .o_dbl_fault(dflt));
	fcis_ctrl dut_u (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
		.i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata), .i_hready(rdy), .o_hrdata(hrdata), .o_hreadyout(rdy),
		.o_hresp(resp), .i_nvm_sec_byte(sec), .i_nvm_keys(keys), .i_nvm_pprot(pp), .i_nvm_eprot(ep),
		.i_nvm_option(op), .i_nvm_blkcfg(bc), .i_nvm_load_err(lerr), .i_nvm_dbl_fault(dflt), .i_sbf_event(sbf),
		.i_stop_req(stop), .o_stop_ack(ack), .o_cmd_irq(cirq), .o_err_irq(eirq), .o_irq(irq),
		.o_read_invalid(rinv), .o_cpu_hold(hold), .o_prot_state(prot), .o_blk_cfg(blk));
	task chk(input [31:0] got, input [31:0] exp);
		begin
			n_checks = n_checks + 1;
			if (got !== exp) begin
				errors = errors + 1;
				$display("mismatch at %0t seen %h expected %h", $time, got, exp);
			end
		end
	endtask
	task close_out;
		begin
			$display("checks %0d mismatches %0d", n_checks, errors);
			if (errors == 0 && n_checks > 0) begin
				$display("[ PASS ]");
			end else begin
				$display("[ FAIL ]");
			end
			$finish;
		end
	endtask
	task bus(input w, input [11:0] a, input [31:0] d, input [31:0] m);
		begin
			hsel <= 1'b1;
			haddr <= a;
			htrans <= 2'h2;
			hwrite <= w;
			hsize <= 3'h2;
			@(posedge i_mclk);
			while (!rdy) @(posedge i_mclk);
			htrans <= 2'h0;
			hwdata <= d;
			if (!w) q.push_back({m, d & m});
			@(posedge i_mclk);
			while (!rdy) @(posedge i_mclk);
		end
	endtask
	task do_reset(input integer w);
		begin
			i_rst_b <= 1'b0;
			repeat (5) @(posedge i_mclk);
			i_rst_b <= 1'b1;
			repeat (w) @(posedge i_mclk);
		end
	endtask
	task bd(input [63:0] k);
		begin
			bus(1'b1, `FCIS_OFF_KEY01, k[31:0], 32'h0);
			bus(1'b1, `FCIS_OFF_KEY23, k[63:32], 32'h0);
			bus(1'b1, `FCIS_OFF_CMD, {24'h0, `FCIS_CMD_BACKDOOR}, 32'h0);
			repeat (2) @(posedge i_mclk);
		end
	endtask
	// Reads are judged here, one queued note per data phase
	always @(posedge i_mclk) begin
		if (rd_pend && rdy) begin
			chk(hrdata & q[0][63:32], q[0][31:0]);
			q.pop_front();
		end
		if (rdy) rd_pend <= hsel && htrans[1] && !hwrite;
	end
	initial begin
		#100000;
		errors = errors + 1;
		close_out;
	end
	initial begin
		do_reset(0);
		bus(1'b0, `FCIS_OFF_STATUS, 32'h0, 32'h80);
		chk(hold, 1'b0);
		repeat (15) @(posedge i_mclk);
		bus(1'b0, `FCIS_OFF_STATUS, 32'h80, 32'h80);
		chk(prot, sec[1:0]);
		chk(blk, bc);
		bus(1'b0, `FCIS_OFF_PPROT, {24'h0, pp}, 32'hFF);
		bus(1'b0, `FCIS_OFF_OPTION, {24'h0, op}, 32'hFF);
		$display("init test done");
		bus(1'b1, `FCIS_OFF_CONFIG, 32'h80, 32'h0);
		repeat (2) @(posedge i_mclk);
		chk(cirq, 1'b1);
		bus(1'b1, `FCIS_OFF_CONFIG, 32'h0, 32'h0);
		repeat (2) @(posedge i_mclk);
		chk(cirq, 1'b0);
		sbf <= 1'b1;
		@(posedge i_mclk);
		sbf <= 1'b0;
		bus(1'b1, `FCIS_OFF_ERRCFG, 32'h1, 32'h0);
		repeat (2) @(posedge i_mclk);
		chk(eirq, 1'b1);
		bus(1'b0, `FCIS_OFF_IRQ_STAT, 32'h2, 32'h2);
		bus(1'b1, `FCIS_OFF_IRQ_EN, 32'h2, 32'h0);
		repeat (2) @(posedge i_mclk);
		chk(irq, 1'b1);
		bus(1'b1, `FCIS_OFF_IRQ_CLR, 32'h2, 32'h0);
		bus(1'b1, `FCIS_OFF_ERRSTAT, 32'h1, 32'h0);
		repeat (2) @(posedge i_mclk);
		chk({irq, eirq}, 2'h0);
		bus(1'b0, 12'h03C, 32'h0, 32'hFFFFFFFF);
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		bus(1'b1, `FCIS_OFF_EPROT, seed, 32'h0);
		bus(1'b0, `FCIS_OFF_EPROT, seed, 32'hFF);
		$display("irq test done");
		bus(1'b1, `FCIS_OFF_CMD, 32'h01, 32'h0);
		stop <= 1'b1;
		n = 0;
		while (!ack && n < 100) begin
			@(posedge i_mclk);
			n = n + 1;
		end
		chk(n >= 10, 1'b1);
		stop <= 1'b0;
		bus(1'b0, `FCIS_OFF_STATUS, 32'h80, 32'h80);
		$display("stop test done");
		bd({seed, ~seed});
		chk(rinv, 1'b1);
		repeat (12) @(posedge i_mclk);
		chk(prot, 2'h0);
		bd(keys);
		chk(rinv, 1'b0);
		repeat (12) @(posedge i_mclk);
		chk(prot, 2'h0);
		do_reset(30);
		bd(keys);
		i_rst_b <= 1'b0;
		@(posedge i_mclk);
		chk(rinv, 1'b0);
		do_reset(30);
		bd(keys);
		repeat (12) @(posedge i_mclk);
		chk(prot, `FCIS_PROT_UNSEC);
		bus(1'b0, `FCIS_OFF_PPROT, {24'h0, pp}, 32'hFF);
		$display("backdoor test done");
		pbyte <= 8'h01;
		prog <= 1'b1;
		@(posedge i_mclk);
		prog <= 1'b0;
		repeat (3) @(posedge i_mclk);
		chk(prot, `FCIS_PROT_UNSEC);
		do_reset(30);
		chk(prot, 2'h1);
		bd(keys);
		chk(rinv, 1'b0);
		pbyte <= 8'h81;
		prog <= 1'b1;
		mode <= 2'h3;
		@(posedge i_mclk);
		prog <= 1'b0;
		do_reset(30);
		bd(64'h0);
		repeat (12) @(posedge i_mclk);
		chk(prot, 2'h1);
		mode <= 2'h1;
		do_reset(30);
		chk(prot, 2'h0);
		bus(1'b0, `FCIS_OFF_PPROT, {24'h0, `FCIS_DEF_PROT}, 32'hFF);
		mode <= 2'h2;
		do_reset(30);
		bus(1'b0, `FCIS_OFF_STATUS, 32'h3, 32'h3);
		$display("security test done");
		close_out;
	end
endmodule
